// ==== design/tmsq_pkg.sv ====
// shared constants and types of the measurement sequencer
`default_nettype none
package tmsq_pkg;
    // register pages and offsets
    localparam logic [2:0] PAGE_CTRL = 3'h2;
    localparam logic [2:0] PAGE_MODE = 3'h4;
    localparam logic [5:0] OFS_FRAME_TYPE_SELECT = 6'h12;
    localparam logic [5:0] OFS_MODE_SELECT = 6'h15;
    localparam logic [5:0] OFS_SHUTTER_CONTROL = 6'h18;
    localparam logic [5:0] OFS_STATUS = 6'h15;
    localparam logic [5:0] OFS_RESULT_DATA = 6'h0c;
    // reset values
    localparam logic [7:0] RST_FRAME_TYPE_SELECT = 8'h00;
    localparam logic [2:0] RST_MODE_SELECT = 3'h0;
    // field positions
    localparam int SHUT_TRIG_BIT = 0;
    localparam int SHUT_AUTO_BIT = 1;
    localparam int STAT_RDY_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int FTS_CNT_LO = 4;
    localparam int FTS_GRAY_LO = 6;
    localparam logic [1:0] FTS_GRAY_CODE = 2'h3;
    // timing, picoseconds as printed, cycles rounded up
    localparam int CLK_PS = 20000;
    localparam int INIT_PS = 18000000;
    localparam int PROC_PS = 38750000;
    localparam int CONV_PS = 15625000;
    localparam int INIT_CYC = (INIT_PS + CLK_PS - 1) / CLK_PS;
    localparam int PROC_CYC = (PROC_PS + CLK_PS - 1) / CLK_PS;
    localparam int CONV_CYC = (CONV_PS + CLK_PS - 1) / CLK_PS;
    // buffer geometry
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;
    localparam int HDR_PASSES = 8;

    typedef enum logic [2:0] {
        MODE_FULL_DEPTH_IMAGER,
        MODE_LOW_NOISE_RANGEFINDER,
        MODE_FAST_SENSITIVE_RANGEFINDER,
        MODE_HIGH_DYNAMIC_RANGEFINDER,
        MODE_FULL_GRAY_IMAGER,
        MODE_BINNED_GRAY_IMAGER
    } tmsq_mode_t;

    // double-rows per frame
    function automatic logic [3:0] groups_of(input tmsq_mode_t m);
        case (m)
            MODE_FULL_DEPTH_IMAGER, MODE_FULL_GRAY_IMAGER: groups_of = 4'h8;
            MODE_BINNED_GRAY_IMAGER: groups_of = 4'h2;
            default: groups_of = 4'h1;
        endcase
    endfunction : groups_of

    // half-row conversions summed into one group
    function automatic logic [3:0] convs_of(input tmsq_mode_t m);
        case (m)
            MODE_LOW_NOISE_RANGEFINDER,
            MODE_HIGH_DYNAMIC_RANGEFINDER: convs_of = 4'h8;
            default: convs_of = 4'h1;
        endcase
    endfunction : convs_of

    // result bytes per group
    function automatic logic [3:0] bytes_of(input tmsq_mode_t m);
        case (m)
            MODE_LOW_NOISE_RANGEFINDER: bytes_of = 4'h3;
            MODE_FAST_SENSITIVE_RANGEFINDER,
            MODE_HIGH_DYNAMIC_RANGEFINDER: bytes_of = 4'h2;
            default: bytes_of = 4'hc;
        endcase
    endfunction : bytes_of

    // result width in bits
    function automatic logic [4:0] width_of(input tmsq_mode_t m);
        case (m)
            MODE_LOW_NOISE_RANGEFINDER: width_of = 5'h12;
            MODE_FAST_SENSITIVE_RANGEFINDER: width_of = 5'h0e;
            MODE_HIGH_DYNAMIC_RANGEFINDER: width_of = 5'h0f;
            default: width_of = 5'h0c;
        endcase
    endfunction : width_of
endpackage : tmsq_pkg
`default_nettype wire

// ==== design/tmsq_fifo.sv ====
// result byte fifo between conversion and register readout
`default_nettype none
module tmsq_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] count
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire do_push = in_valid && in_ready;
    wire do_pop = out_valid && out_ready;

    assign in_ready = (cnt_r != (AW+1)'(D)) || out_ready;
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rp_r];
    assign count = cnt_r;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= do_push ? wp_r + 1'b1 : wp_r;
            rp_r <= do_pop ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : tmsq_fifo
`default_nettype wire

// ==== design/tmsq_sequencer.sv ====
// measurement sequencer: registers, frame timing and result buffering
`default_nettype none
// How it works
// - frame-type bits 5:4 cleared and 7:6 at 11 select grayscale.
// - with grayscale selected every trigger runs the selected mode with gray_frame raised.
// - switched grayscale results use the distance mode readout format.
// - switched grayscale runs exactly one frame per trigger.
// - next double-row converts while the previous one is read out.
// - first illumination 18 us after the trigger.
// - first row conversion 38.75 us after last illumination.
// - one half-row conversion takes 15.625 us.
// - full depth imager converts 125 us per frame, 12-bit results.
// - fast sensitive mode bins 4 pixels, 15.63 us, 14-bit result.
// - low noise mode sums 64 pixels into 18 bits in 125 us.
// - high dynamic mode always uses 8 integrations, 15-bit result.
// - binned gray imager bins 4 pixels, 12 bits, 31.25 us.
// - writing shutter bit 0 starts one cycle; frame-type bits 5:4 set frame count.
// - the trigger bit clears itself once taken.
// - next frame starts right after the last byte is read.
// - shutter bit 1 set means cycle follows cycle without stop.
// - trigger during last double-row readout of last frame reruns.
// - a continuing cycle starts with no idle gap.
// - data-ready marks one full double-row of results available.
module tmsq_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [2:0] reg_page,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // analog front end
    input wire logic [15:0] int_len,
    input wire logic [17:0] adc_sample,
    output logic illum_en,
    output logic conv_active,
    output logic gray_frame,
    // status pins
    output logic data_rdy,
    output logic busy
);
    typedef enum {
        ST_IDLE, ST_INIT, ST_INTEG, ST_PROC, ST_CONV, ST_PUSH, ST_DRAIN
    } tmsq_state_t;

    tmsq_state_t state_r, state_nxt;
    logic [7:0] fts_r;
    logic [2:0] mode_sel_r;
    logic trig_r, auto_r;
    tmsq_pkg::tmsq_mode_t cur_mode_r;
    logic cur_gray_r;
    logic [2:0] frames_left_r;
    logic [15:0] cnt_r;
    logic [3:0] pass_r, conv_r, group_r, byte_r, rd_byte_r;
    logic [1:0] rdy_groups_r;
    logic [23:0] acc_r;
    logic [7:0] reg_rdata_r;

    // register decode
    wire hit_fts = reg_page == tmsq_pkg::PAGE_MODE &&
        reg_addr == tmsq_pkg::OFS_FRAME_TYPE_SELECT;
    wire hit_mode = reg_page == tmsq_pkg::PAGE_MODE &&
        reg_addr == tmsq_pkg::OFS_MODE_SELECT;
    wire hit_shut = reg_page == tmsq_pkg::PAGE_CTRL &&
        reg_addr == tmsq_pkg::OFS_SHUTTER_CONTROL;
    wire hit_stat = reg_page == tmsq_pkg::PAGE_CTRL &&
        reg_addr == tmsq_pkg::OFS_STATUS;
    wire hit_data = reg_page == tmsq_pkg::PAGE_CTRL &&
        reg_addr == tmsq_pkg::OFS_RESULT_DATA;
    wire wr_shut = reg_wr && hit_shut;
    wire wr_trig = wr_shut && reg_wdata[tmsq_pkg::SHUT_TRIG_BIT];

    // fifo hookup
    logic fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data, push_byte;
    logic [4:0] fifo_count;
    wire pop = reg_rd && hit_data && fifo_out_valid;
    wire push = state_r == ST_PUSH;
    wire push_take = push && fifo_in_ready;

    tmsq_fifo #(.W(tmsq_pkg::FIFO_W), .D(tmsq_pkg::FIFO_D)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_byte),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // per-mode geometry of the running cycle
    wire [3:0] n_groups = tmsq_pkg::groups_of(cur_mode_r);
    wire [3:0] n_convs = tmsq_pkg::convs_of(cur_mode_r);
    wire [3:0] n_bytes = tmsq_pkg::bytes_of(cur_mode_r);
    wire [4:0] res_w = tmsq_pkg::width_of(cur_mode_r);
    wire [3:0] n_passes = cur_mode_r ==
        tmsq_pkg::MODE_HIGH_DYNAMIC_RANGEFINDER ?
        4'(tmsq_pkg::HDR_PASSES) : 4'h1;

    // frame count and grayscale switch sampled at cycle start
    wire [1:0] fts_cnt = fts_r[tmsq_pkg::FTS_CNT_LO +: 2];
    wire fts_gray = fts_cnt == 2'h0 &&
        fts_r[tmsq_pkg::FTS_GRAY_LO +: 2] == tmsq_pkg::FTS_GRAY_CODE;
    wire [2:0] frames_sel = fts_gray ? 3'h0 :
        fts_cnt == 2'h0 ? 3'h3 : fts_cnt == 2'h1 ? 3'h1 : 3'h0;
    wire gray_mode = cur_mode_r == tmsq_pkg::MODE_FULL_GRAY_IMAGER ||
        cur_mode_r == tmsq_pkg::MODE_BINNED_GRAY_IMAGER;

    // result word clipped to the mode width; 12-bit packs msb,nibbles,msb
    wire [23:0] res_mask = (24'h1 << res_w) - 24'h1;
    wire [23:0] res = acc_r & res_mask;
    wire [1:0] b3 = 2'(byte_r % 4'h3);
    wire [3:0] b_rem = n_bytes - 4'h1 - byte_r;
    wire [7:0] wide_byte = 8'(res >> {b_rem[1:0], 3'h0});
    wire [7:0] twelve_byte = b3 == 2'h1 ? {res[3:0], res[3:0]} : res[11:4];
    assign push_byte = res_w == 5'h0c ? twelve_byte : wide_byte;

    // phase ends
    wire init_done = cnt_r == 16'(tmsq_pkg::INIT_CYC - 1);
    wire integ_done = cnt_r == int_len;
    wire proc_done = cnt_r == 16'(tmsq_pkg::PROC_CYC - 1);
    wire conv_done = cnt_r == 16'(tmsq_pkg::CONV_CYC - 1);
    wire last_byte = byte_r == n_bytes - 4'h1;
    wire last_group = group_r == n_groups - 4'h1;
    wire drained = fifo_count == 5'h0 && rdy_groups_r == 2'h0;
    wire last_read = state_r == ST_DRAIN && frames_left_r == 3'h0;
    wire start_idle = state_r == ST_IDLE && (trig_r || auto_r);
    wire cycle_end = state_r == ST_DRAIN && drained && frames_left_r == 3'h0;
    wire restart = cycle_end && (trig_r || auto_r);
    wire take_trig = start_idle || restart;
    wire rd_last = pop && rd_byte_r == n_bytes - 4'h1;
    wire grp_pushed = push_take && last_byte;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: state_nxt = start_idle ? ST_INIT : ST_IDLE;
            ST_INIT: state_nxt = init_done ? ST_INTEG : ST_INIT;
            ST_INTEG: state_nxt = integ_done && pass_r == n_passes - 4'h1 ?
                ST_PROC : ST_INTEG;
            ST_PROC: state_nxt = proc_done ? ST_CONV : ST_PROC;
            ST_CONV: state_nxt = conv_done && conv_r == n_convs - 4'h1 ?
                ST_PUSH : ST_CONV;
            // next group converts while the host still reads
            ST_PUSH: state_nxt = !grp_pushed ? ST_PUSH :
                last_group ? ST_DRAIN : ST_CONV;
            ST_DRAIN: begin
                if (drained && frames_left_r != 3'h0) begin
                    state_nxt = ST_INTEG;
                end else if (restart) begin
                    state_nxt = ST_INIT;
                end else if (cycle_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // counters restart on every state change
    wire [15:0] cnt_nxt = state_nxt != state_r ? 16'h0 :
        state_r == ST_INTEG && integ_done ? 16'h0 :
        state_r == ST_CONV && conv_done ? 16'h0 : cnt_r + 16'h1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // registers written by the host
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fts_r <= tmsq_pkg::RST_FRAME_TYPE_SELECT;
            mode_sel_r <= tmsq_pkg::RST_MODE_SELECT;
            auto_r <= 1'b0;
        end else begin
            if (reg_wr && hit_fts) begin
                fts_r <= reg_wdata;
            end
            if (reg_wr && hit_mode) begin
                mode_sel_r <= reg_wdata[2:0];
            end
            if (wr_shut) begin
                auto_r <= reg_wdata[tmsq_pkg::SHUT_AUTO_BIT];
            end
        end
    end

    // trigger kept only when idle or in the last readout; write beats clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trig_r <= 1'b0;
        end else if (wr_trig && (state_r == ST_IDLE || last_read)) begin
            trig_r <= 1'b1;
        end else if (take_trig) begin
            trig_r <= 1'b0;
        end
    end

    // cycle set-up; selections frozen for the whole cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_mode_r <= tmsq_pkg::MODE_FULL_DEPTH_IMAGER;
            cur_gray_r <= 1'b0;
            frames_left_r <= '0;
        end else if (take_trig) begin
            // unknown codes fall back to the full depth imager
            cur_mode_r <= mode_sel_r > 3'h5 ?
                tmsq_pkg::MODE_FULL_DEPTH_IMAGER :
                tmsq_pkg::tmsq_mode_t'(mode_sel_r);
            cur_gray_r <= fts_gray;
            frames_left_r <= frames_sel;
        end else if (state_r == ST_DRAIN && drained &&
                frames_left_r != 3'h0) begin
            frames_left_r <= frames_left_r - 3'h1;
        end
    end

    // pass, conversion, group and byte counters
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pass_r <= '0;
            conv_r <= '0;
            group_r <= '0;
            byte_r <= '0;
            acc_r <= '0;
        end else begin
            if (state_r != ST_INTEG) begin
                pass_r <= '0;
            end else if (integ_done) begin
                pass_r <= pass_r + 4'h1;
            end
            if (state_r == ST_CONV && conv_done) begin
                conv_r <= conv_r + 4'h1;
                acc_r <= acc_r + {6'h0, adc_sample};
            end else if (state_r == ST_PUSH) begin
                conv_r <= '0;
                if (grp_pushed) begin
                    acc_r <= '0;
                end
            end
            if (state_r == ST_INTEG) begin
                group_r <= '0;
            end else if (grp_pushed) begin
                group_r <= group_r + 4'h1;
            end
            if (grp_pushed) begin
                byte_r <= '0;
            end else if (push_take) begin
                byte_r <= byte_r + 4'h1;
            end
        end
    end

    // readable groups: one is added when pushed, dropped on its last read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdy_groups_r <= '0;
            rd_byte_r <= '0;
        end else begin
            rdy_groups_r <= rdy_groups_r + 2'(grp_pushed) - 2'(rd_last);
            if (rd_last) begin
                rd_byte_r <= '0;
            end else if (pop) begin
                rd_byte_r <= rd_byte_r + 4'h1;
            end
        end
    end

    // register read data
    wire [7:0] status_val = {6'h0, state_r != ST_IDLE, rdy_groups_r != 2'h0};
    wire [7:0] shut_val = {6'h0, auto_r, trig_r};
    wire [7:0] rd_val = hit_fts ? fts_r :
        hit_mode ? {5'h0, mode_sel_r} :
        hit_shut ? shut_val :
        hit_stat ? status_val :
        hit_data && fifo_out_valid ? fifo_out_data : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_r <= '0;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_val;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign illum_en = state_r == ST_INTEG;
    assign conv_active = state_r == ST_CONV;
    assign gray_frame = state_r != ST_IDLE && (cur_gray_r || gray_mode);
    assign data_rdy = rdy_groups_r != 2'h0;
    assign busy = state_r != ST_IDLE;

    // checks; dwell kept apart from cnt_r so repeated conversions count as one phase
    logic [15:0] dwell_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dwell_r <= '0;
        end else begin
            dwell_r <= state_nxt != state_r ? 16'h0 : dwell_r + 16'h1;
        end
    end

    AST_TRIG_CLEAR: assert property (
        @(posedge clk) disable iff (!resetn)
        start_idle && !wr_trig |=> !trig_r)
        else $error("trigger bit not cleared after start");
    AST_INIT_TIME: assert property (
        @(posedge clk) disable iff (!resetn)
        state_r == ST_INIT && state_nxt != ST_INIT |->
        state_nxt == ST_INTEG && dwell_r == 16'(tmsq_pkg::INIT_CYC - 1))
        else $error("illumination not 18 us after trigger");
    AST_PROC_TIME: assert property (
        @(posedge clk) disable iff (!resetn)
        state_r == ST_PROC && state_nxt != ST_PROC |->
        state_nxt == ST_CONV && dwell_r == 16'(tmsq_pkg::PROC_CYC - 1))
        else $error("processing delay wrong");
    AST_CONV_TIME: assert property (
        @(posedge clk) disable iff (!resetn)
        state_r == ST_CONV && conv_done |->
        dwell_r + 16'h1 == 16'(tmsq_pkg::CONV_CYC) * (16'(conv_r) + 16'h1))
        else $error("half row conversion time wrong");
    AST_GRAY_ONE: assert property (
        @(posedge clk) disable iff (!resetn)
        take_trig && fts_gray |=> frames_left_r == 3'h0)
        else $error("switched grayscale runs more than one frame");
    AST_NEXT_FRAME: assert property (
        @(posedge clk) disable iff (!resetn)
        state_r == ST_DRAIN && drained && frames_left_r != 3'h0 |=>
        state_r == ST_INTEG && illum_en)
        else $error("next frame not started after readout");
    AST_CONTINUE: assert property (
        @(posedge clk) disable iff (!resetn)
        cycle_end && auto_r |=> state_r == ST_INIT && busy)
        else $error("continuous cycle not restarted at once");
    AST_READY_FULL: assert property (
        @(posedge clk) disable iff (!resetn)
        grp_pushed |=> data_rdy && fifo_count >= 5'(n_bytes))
        else $error("data ready without a full double-row");
    AST_MODE_HELD: assert property (
        @(posedge clk) disable iff (!resetn)
        busy && !$past(take_trig) && $past(busy) |-> $stable(cur_mode_r))
        else $error("mode changed inside a cycle");
endmodule : tmsq_sequencer
`default_nettype wire

// ==== bench/tmsq_host.sv ====
// host model: drives register writes and reads toward the sequencer
`default_nettype none
module tmsq_host (
    // clock
    input wire logic clk,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [2:0] reg_page,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // status pin
    input wire logic data_rdy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] saved;

    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_page = 3'h0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
    end

    // released lines show the inverse, so a stale value never looks valid
    task automatic xfer(input logic wr, input logic [2:0] pg,
            input logic [5:0] ad, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_page = pg;
        reg_addr = ad;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_page = ~pg;
        reg_addr = ~ad;
        reg_wdata = ~d;
    endtask : xfer

    task automatic wr(input logic [2:0] pg, input logic [5:0] ad,
            input logic [7:0] d);
        xfer(1'b1, pg, ad, d);
    endtask : wr

    task automatic rd(input logic [2:0] pg, input logic [5:0] ad);
        xfer(1'b0, pg, ad, 8'h00);
    endtask : rd

    // watches the pin instead of polling status, bounded
    task automatic wait_ready(output logic ok);
        int k;
        k = 0;
        while (data_rdy !== 1'b1 && k < 20000) begin
            @(posedge clk);
            #2;
            k++;
        end
        ok = (data_rdy === 1'b1);
    endtask : wait_ready

    task automatic gray_on();
        rd(tmsq_pkg::PAGE_MODE, tmsq_pkg::OFS_FRAME_TYPE_SELECT);
        saved = reg_rdata;
        wr(tmsq_pkg::PAGE_MODE, tmsq_pkg::OFS_FRAME_TYPE_SELECT, 8'hc0);
    endtask : gray_on

    task automatic gray_off();
        wr(tmsq_pkg::PAGE_MODE, tmsq_pkg::OFS_FRAME_TYPE_SELECT, saved);
    endtask : gray_off
endmodule : tmsq_host
`default_nettype wire

// ==== bench/tof_measurement_sequencer_test.sv ====
// self-checking bench of the measurement sequencer
`default_nettype none
module tof_measurement_sequencer_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk;
    logic resetn;
    logic [15:0] int_len;
    logic [17:0] adc_sample;
    wire logic reg_wr, reg_rd, illum_en, conv_active, gray_frame;
    wire logic data_rdy, busy;
    wire logic [2:0] reg_page;
    wire logic [5:0] reg_addr;
    wire logic [7:0] reg_wdata, reg_rdata;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int conv_cyc = 0;
    int ov_cyc = 0;
    int mark = 0;
    int c0;
    int o0;
    logic rd_seen = 1'b0;
    logic [15:0] notes[$];
    logic [15:0] note;
    logic [8:0] rtab[6] = '{9'h112, 9'h115, 9'h098, 9'h095, 9'h0bf, 9'h08c};

    tmsq_sequencer uut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_len(int_len),
        .adc_sample(adc_sample), .illum_en(illum_en),
        .conv_active(conv_active), .gray_frame(gray_frame),
        .data_rdy(data_rdy), .busy(busy));
    tmsq_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .data_rdy(data_rdy));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string m);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk

    always @(posedge clk) begin
        cyc <= cyc + 1;
        adc_sample <= #1 18'($urandom);
        if (cyc == 100000) begin
            chk(32'h0, 32'h1, "timeout");
            complete_run();
        end
    end

    // answer watcher: oldest note against each read answer
    always @(posedge clk) begin
        rd_seen <= reg_rd;
        conv_cyc <= conv_cyc + int'(conv_active === 1'b1);
        ov_cyc <= ov_cyc + int'(conv_active === 1'b1 && data_rdy === 1'b1);
        if (rd_seen) begin
            note = notes.pop_front();
            if (note[15:8] != 8'h00) begin
                chk({24'h0, reg_rdata & note[15:8]}, {24'h0, note[7:0]},
                    "read data");
            end
        end
    end

    function automatic logic cond(input int w);
        case (w)
            0: cond = illum_en === 1'b1;
            1: cond = illum_en === 1'b0;
            2: cond = conv_active === 1'b1;
            3: cond = conv_active === 1'b0;
            5: cond = busy === 1'b0;
            default: cond = busy === 1'b1;
        endcase
    endfunction : cond

    // bounded wait; cycles since mark must land in the window
    task automatic span(input int w, input int lo, input int hi,
            input string m);
        int k;
        k = 0;
        while (!cond(w) && k < 20000) begin
            @(posedge clk);
            #2;
            k++;
        end
        chk(32'(cyc - mark >= lo && cyc - mark <= hi), 32'h1, m);
        mark = cyc;
    endtask : span

    task automatic rd(input logic [2:0] pg, input logic [5:0] a,
            input logic [15:0] nt);
        notes.push_back(nt);
        host.rd(pg, a);
    endtask : rd

    task automatic take(input int n);
        logic ok;
        host.wait_ready(ok);
        chk(32'(ok), 32'h1, "data ready");
        repeat (n) rd(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_RESULT_DATA, 16'h0);
        mark = cyc;
    endtask : take

    task automatic trig(input logic [7:0] v);
        host.wr(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_SHUTTER_CONTROL, v);
        mark = cyc;
    endtask : trig

    task automatic setup(input logic [7:0] mode, input logic [7:0] ft);
        host.wr(tmsq_pkg::PAGE_MODE, tmsq_pkg::OFS_MODE_SELECT, mode);
        host.wr(tmsq_pkg::PAGE_MODE, tmsq_pkg::OFS_FRAME_TYPE_SELECT, ft);
        int_len = 16'($urandom_range(63, 7));
    endtask : setup

    initial begin
        resetn = 1'b0;
        int_len = 16'h0007;
        adc_sample = 18'h00000;
        void'($urandom(32'ha5eeaa37));
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b1;
        // reset values, unmapped and read-only places stay zero
        foreach (rtab[i]) rd(rtab[i][8:6], rtab[i][5:0], 16'hff00);
        host.wr(3'h2, 6'h3f, 8'hff);
        host.wr(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_STATUS, 8'hff);
        rd(3'h2, 6'h3f, 16'hff00);
        rd(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_STATUS, 16'hff00);
        $display("test registers done");
        setup(8'h02, 8'h20);
        trig(8'h01);
        rd(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_SHUTTER_CONTROL, 16'h0100);
        span(0, tmsq_pkg::INIT_CYC, tmsq_pkg::INIT_CYC + 4, "init");
        span(1, int_len, int_len + 2, "integration");
        span(2, tmsq_pkg::PROC_CYC - 1, tmsq_pkg::PROC_CYC + 3, "proc");
        span(3, tmsq_pkg::CONV_CYC - 1, tmsq_pkg::CONV_CYC + 1, "conv");
        chk(32'(gray_frame), 32'h0, "distance frame");
        take(2);
        span(5, 0, 10, "single frame end");
        $display("test single trigger done");
        notes.push_back(16'hff20);
        host.gray_on();
        trig(8'h01);
        span(0, tmsq_pkg::INIT_CYC, tmsq_pkg::INIT_CYC + 4, "gray init");
        chk(32'(gray_frame), 32'h1, "gray frame");
        take(2);
        span(5, 0, 10, "one gray frame");
        host.gray_off();
        rd(tmsq_pkg::PAGE_MODE, tmsq_pkg::OFS_FRAME_TYPE_SELECT, 16'hff20);
        $display("test gray switch done");
        setup(8'h02, 8'h10);
        trig(8'h01);
        host.wr(tmsq_pkg::PAGE_MODE, tmsq_pkg::OFS_MODE_SELECT, 8'h00);
        trig(8'h01);
        take(2);
        span(0, 1, 3, "next frame");
        take(2);
        span(5, 0, 10, "two frames end");
        $display("test two frames done");
        setup(8'h00, 8'h20);
        c0 = conv_cyc;
        o0 = ov_cyc;
        trig(8'h01);
        repeat (8) take(12);
        span(5, 0, 10, "imager end");
        chk(32'(conv_cyc - c0 >= 8 * tmsq_pkg::CONV_CYC - 8 &&
            conv_cyc - c0 <= 8 * tmsq_pkg::CONV_CYC + 8), 32'h1, "total conv");
        chk(32'(ov_cyc != o0), 32'h1, "convert during readout");
        $display("test imager done");
        setup(8'h05, 8'h20);
        c0 = conv_cyc;
        trig(8'h01);
        take(12);
        chk(32'(gray_frame), 32'h1, "binned gray");
        take(12);
        span(5, 0, 10, "binned end");
        chk(32'(conv_cyc - c0 >= 2 * tmsq_pkg::CONV_CYC - 2 &&
            conv_cyc - c0 <= 2 * tmsq_pkg::CONV_CYC + 2), 32'h1, "gray conv");
        $display("test binned gray done");
        setup(8'h02, 8'h20);
        trig(8'h02);
        rd(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_SHUTTER_CONTROL, 16'hff02);
        take(2);
        span(0, tmsq_pkg::INIT_CYC, tmsq_pkg::INIT_CYC + 6, "autorun");
        host.wr(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_SHUTTER_CONTROL, 8'h00);
        take(1);
        host.wr(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_SHUTTER_CONTROL, 8'h01);
        rd(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_RESULT_DATA, 16'h0000);
        mark = cyc;
        span(0, tmsq_pkg::INIT_CYC, tmsq_pkg::INIT_CYC + 6, "late trigger");
        take(2);
        span(5, 0, 10, "autorun stop");
        rd(tmsq_pkg::PAGE_CTRL, tmsq_pkg::OFS_RESULT_DATA, 16'hff00);
        $display("test autorun done");
        complete_run();
    end
endmodule : tof_measurement_sequencer_test
`default_nettype wire
